// >>> hdl/gpp_pkg.sv
package gpp_pkg;
  // ----------------------------------------
  // Build-time choices
  // ----------------------------------------
  typedef enum logic [1:0] {
    GPP_DIR_INPUT,
    GPP_DIR_OUTPUT,
    GPP_DIR_INOUT,
    GPP_DIR_BIDIR
  } gpp_dir_mode_e;

  typedef enum logic [1:0] {
    GPP_EDGE_RISE,
    GPP_EDGE_FALL,
    GPP_EDGE_ANY
  } gpp_edge_kind_e;

  typedef enum logic {
    GPP_IRQ_LEVEL,
    GPP_IRQ_EDGE
  } gpp_irq_mode_e;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int GPP_MAX_WIDTH = 32;
  localparam logic [31:0] GPP_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] GPP_DIR_RST = 32'h0000_0000;
  localparam logic [31:0] GPP_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] GPP_CAPT_RST = 32'h0000_0000;
endpackage : gpp_pkg

// >>> hdl/gpp_port.sv
`timescale 1ns/1ns
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter gpp_dir_mode_e DIR_MODE = GPP_DIR_BIDIR,
  parameter bit CAPT_EN = 1'b1,
  parameter gpp_edge_kind_e EDGE_KIND = GPP_EDGE_RISE,
  parameter bit CLR_EN = 1'b1,
  parameter bit IRQ_EN = 1'b1,
  parameter gpp_irq_mode_e IRQ_MODE = GPP_IRQ_EDGE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host writes (one-cycle strobes with data)
  input wire logic data_wr,
  input wire logic [WIDTH-1:0] data_wdata,
  input wire logic dir_wr,
  input wire logic [WIDTH-1:0] dir_wdata,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] mask_wdata,
  input wire logic capt_wr,
  input wire logic [WIDTH-1:0] capt_wdata,
  // Host read-back
  output logic [WIDTH-1:0] data_rdata,
  output logic [WIDTH-1:0] dir_rdata,
  output logic [WIDTH-1:0] mask_rdata,
  output logic [WIDTH-1:0] capt_rdata,
  output logic irq,
  // Port pins
  input wire logic [WIDTH-1:0] port_in,
  output logic [WIDTH-1:0] port_out,
  output logic [WIDTH-1:0] port_oe
);

  // ----------------------------------------
  // Build-time feature decode
  // ----------------------------------------
  localparam bit HAS_IN = (DIR_MODE != GPP_DIR_OUTPUT);
  localparam bit HAS_OUT = (DIR_MODE != GPP_DIR_INPUT);
  localparam bit IS_BIDIR = (DIR_MODE == GPP_DIR_BIDIR);
  localparam bit HAS_CAPT = CAPT_EN && HAS_IN;
  localparam bit HAS_IRQ = IRQ_EN && HAS_IN;
  localparam logic [WIDTH-1:0] ZERO = '0;

  // Edge kind is a constant; no write path reaches it
  function automatic logic [WIDTH-1:0] edge_hits(input logic [WIDTH-1:0] cur,
                                                 input logic [WIDTH-1:0] prev);
    case (EDGE_KIND)
      GPP_EDGE_RISE: edge_hits = cur & ~prev;
      GPP_EDGE_FALL: edge_hits = ~cur & prev;
      GPP_EDGE_ANY: edge_hits = cur ^ prev;
      default: edge_hits = ZERO;
    endcase
  endfunction : edge_hits

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [WIDTH-1:0] samp_reg, samp_next;
  logic [WIDTH-1:0] prev_reg, prev_next;
  logic [WIDTH-1:0] out_reg, out_next;
  logic [WIDTH-1:0] dir_reg, dir_next;
  logic [WIDTH-1:0] mask_reg, mask_next;
  logic [WIDTH-1:0] capt_reg, capt_next;
  logic irq_reg, irq_next;
  logic [WIDTH-1:0] hits;

  always_comb begin
    samp_next = HAS_IN ? port_in : ZERO;
    prev_next = samp_reg;
    hits = HAS_CAPT ? edge_hits(samp_reg, prev_reg) : ZERO;
    out_next = out_reg;
    if (data_wr && HAS_OUT) begin
      out_next = data_wdata;
    end
    dir_next = dir_reg;
    if (dir_wr && IS_BIDIR) begin
      dir_next = dir_wdata;
    end
    mask_next = mask_reg;
    if (mask_wr && HAS_IRQ) begin
      mask_next = mask_wdata;
    end
    capt_next = capt_reg;
    // Any write clears all when per-bit clearing is off
    if (capt_wr) begin
      capt_next = CLR_EN ? (capt_reg & ~capt_wdata) : ZERO;
    end
    // Set after clear so a fresh edge is never lost
    capt_next = capt_next | hits;
    irq_next = 1'b0;
    if (HAS_IRQ) begin
      if (IRQ_MODE == GPP_IRQ_LEVEL) begin
        irq_next = |(samp_next & mask_next);
      end else begin
        irq_next = |(capt_next & mask_next);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Preload both samples from the pins so a pin idling high gives no false edge
      samp_reg <= samp_next;
      prev_reg <= samp_next;
      out_reg <= GPP_DATA_RST[WIDTH-1:0];
      dir_reg <= GPP_DIR_RST[WIDTH-1:0];
      mask_reg <= GPP_MASK_RST[WIDTH-1:0];
      capt_reg <= GPP_CAPT_RST[WIDTH-1:0];
      irq_reg <= 1'b0;
    end else begin
      samp_reg <= samp_next;
      prev_reg <= prev_next;
      out_reg <= out_next;
      dir_reg <= dir_next;
      mask_reg <= mask_next;
      capt_reg <= capt_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_rdata = samp_reg;
  assign dir_rdata = dir_reg;
  assign mask_rdata = mask_reg;
  assign capt_rdata = capt_reg;
  assign irq = irq_reg;
  assign port_out = out_reg;
  // Outputs-only and separate modes always drive; bidir floats on zero
  assign port_oe = IS_BIDIR ? dir_reg : (HAS_OUT ? ~ZERO : ZERO);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_width_range: assert property (WIDTH >= 1 && WIDTH <= GPP_MAX_WIDTH)
    else $error("port width out of range");
  a_read_input: assert property (##1 data_rdata == $past(port_in) || !HAS_IN)
    else $error("data read does not show input");
  a_write_out: assert property (data_wr && HAS_OUT |=> port_out == $past(data_wdata))
    else $error("data write not driven");
  a_read_sep: assert property (data_wr && HAS_IN ##1 1 |-> data_rdata == $past(port_in))
    else $error("read echoes write");
  a_edge_set: assert property (HAS_CAPT && hits[0] |=> capt_rdata[0])
    else $error("edge not captured");
  a_capt_hold: assert property (capt_rdata[0] && !capt_wr |=> capt_rdata[0])
    else $error("capture bit lost");
  a_capt_clr: assert property (CLR_EN && capt_wr && !capt_wdata[0] && capt_rdata[0]
                                |=> capt_rdata[0])
    else $error("unwritten bit cleared");
  a_dir_oe: assert property (IS_BIDIR && dir_wr |=> port_oe == $past(dir_wdata))
    else $error("direction not applied");
  a_irq_mask: assert property (mask_rdata == ZERO && !mask_wr |=> !irq)
    else $error("masked interrupt raised");
  a_irq_level: assert property (HAS_IRQ && IRQ_MODE == GPP_IRQ_LEVEL
                                 |-> irq == |(data_rdata & mask_rdata))
    else $error("level interrupt wrong");
  a_irq_edge: assert property (HAS_IRQ && IRQ_MODE == GPP_IRQ_EDGE
                                |-> irq == |(capt_rdata & mask_rdata))
    else $error("edge interrupt wrong");
  a_samp_prev: assert property (##1 prev_reg == $past(samp_reg))
    else $error("previous sample lost");

  c_edge_seen: cover property (hits != ZERO ##1 capt_rdata != ZERO);
  c_irq_rise: cover property (!irq ##1 irq);
  c_capt_clear: cover property (capt_rdata != ZERO ##1 capt_wr ##1 capt_rdata == ZERO);
  c_float: cover property (port_oe != ~ZERO);

endmodule : gpp_port
`default_nettype wire

// >>> tb/gpp_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Far-side pin model
// ----------------------------------------
// The far side always drives, so a released pin never shows a stale value
module gpp_pin_model #(
  parameter int WIDTH = 8
) (
  // Port side
  input wire logic [WIDTH-1:0] port_out,
  input wire logic [WIDTH-1:0] port_oe,
  // Far side
  input wire logic [WIDTH-1:0] ext_val,
  output logic [WIDTH-1:0] pin
);
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pin[i] = port_oe[i] ? port_out[i] : ext_val[i];
    end
  end
endmodule : gpp_pin_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic data_wr = 1'b0;
  logic dir_wr = 1'b0;
  logic mask_wr = 1'b0;
  logic capt_wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] data_rdata, dir_rdata, mask_rdata, capt_rdata, port_out, port_oe, pin;
  logic irq;
  logic [7:0] b_data_rdata, b_dir_rdata, b_mask_rdata, b_capt_rdata, b_port_out, b_port_oe;
  logic b_irq;
  int num_errors = 0;
  int checks = 0;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  gpp_port #(.WIDTH(8)) u_gpp_port (.clk(clk), .reset_n(reset_n),
    .data_wr(data_wr), .data_wdata(wdata), .dir_wr(dir_wr), .dir_wdata(wdata),
    .mask_wr(mask_wr), .mask_wdata(wdata), .capt_wr(capt_wr), .capt_wdata(wdata),
    .data_rdata(data_rdata), .dir_rdata(dir_rdata), .mask_rdata(mask_rdata),
    .capt_rdata(capt_rdata), .irq(irq), .port_in(pin), .port_out(port_out),
    .port_oe(port_oe));
  gpp_pin_model #(.WIDTH(8)) u_gpp_pin_model (.port_out(port_out), .port_oe(port_oe),
    .ext_val(ext_val), .pin(pin));
  // Second build: separate buses, any edge, clear-all, level interrupt
  if (1) begin : g_alt
    gpp_port #(.WIDTH(8), .DIR_MODE(gpp_pkg::GPP_DIR_INOUT), .EDGE_KIND(gpp_pkg::GPP_EDGE_ANY),
      .CLR_EN(1'b0), .IRQ_MODE(gpp_pkg::GPP_IRQ_LEVEL)) u_gpp_port (.clk(clk),
      .reset_n(reset_n), .data_wr(data_wr), .data_wdata(wdata), .dir_wr(dir_wr),
      .dir_wdata(wdata), .mask_wr(mask_wr), .mask_wdata(wdata), .capt_wr(capt_wr),
      .capt_wdata(wdata), .data_rdata(b_data_rdata), .dir_rdata(b_dir_rdata),
      .mask_rdata(b_mask_rdata), .capt_rdata(b_capt_rdata), .irq(b_irq),
      .port_in(ext_val), .port_out(b_port_out), .port_oe(b_port_oe));
  end
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Sel: 0 data, 1 direction, 2 mask, 3 capture clear
  task automatic wr(input logic [1:0] sel, input logic [7:0] val);
    @(negedge clk);
    wdata = val;
    {data_wr, dir_wr, mask_wr, capt_wr} = 4'b1000 >> sel;
    @(negedge clk);
    {data_wr, dir_wr, mask_wr, capt_wr} = 4'b0000;
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(2);
    reset_n = 1'b1;
    `CHK({dir_rdata, mask_rdata, capt_rdata, port_oe, port_out, irq}, 41'h0)
    `CHK({b_dir_rdata, b_mask_rdata, b_capt_rdata, b_port_out, b_irq}, 33'h0)
    `CHK(b_port_oe, 8'hFF)
    wr(2'd0, 8'hA5);
    `CHK(port_oe, 8'h00)
    `CHK(b_port_out, 8'hA5)
    wr(2'd1, 8'h0F);
    // Low nibble now driven by the port, high nibble rises from outside
    ext_val = 8'h30;
    cyc(3);
    `CHK(port_out, 8'hA5)
    `CHK(port_oe, 8'h0F)
    `CHK(data_rdata, 8'h35)
    `CHK(capt_rdata, 8'h35)
    `CHK(irq, 1'b0)
    `CHK(dir_rdata, 8'h0F)
    `CHK(b_dir_rdata, 8'h00)
    `CHK(b_data_rdata, 8'h30)
    `CHK(b_capt_rdata, 8'h30)
    wr(2'd2, 8'h04);
    `CHK(irq, 1'b1)
    `CHK(mask_rdata, 8'h04)
    `CHK(b_mask_rdata, 8'h04)
    `CHK(b_irq, 1'b0)
    wr(2'd3, 8'h14);
    `CHK(capt_rdata, 8'h21)
    `CHK(irq, 1'b0)
    `CHK(b_capt_rdata, 8'h00)
    // Falling edges must not set capture bits in rising mode
    ext_val = 8'h00;
    cyc(3);
    `CHK(data_rdata, 8'h05)
    `CHK(capt_rdata, 8'h21)
    `CHK(b_data_rdata, 8'h00)
    `CHK(b_capt_rdata, 8'h30)
    wr(2'd3, 8'hFF);
    `CHK(capt_rdata, 8'h00)
    `CHK(b_capt_rdata, 8'h00)
    // Level interrupt follows the sampled input, gated by the mask
    ext_val = 8'h04;
    cyc(2);
    `CHK(b_irq, 1'b1)
    `CHK(b_capt_rdata, 8'h04)
    `CHK(capt_rdata, 8'h00)
    ext_val = 8'h08;
    cyc(2);
    `CHK(b_irq, 1'b0)
    tally_and_finish();
  end
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
